// ### dv/ebms_periph_model.sv
// Behavioural external peripheral facing the bus sequencer
module ebms_periph_model
    import ebms_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Pins from the device
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe_n,
    input  wire logic        addr_latch_en,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic        addr_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        read_write,
    // Answers to the device
    output logic [7:0]       data_in,
    output logic             ready_pin,
    output logic             transfer_ack_n,
    // Bench control and capture
    input  wire logic [7:0]  stall,
    input  wire logic [7:0]  rd_byte,
    output logic [7:0]       lat_addr,
    output logic [23:0]      bus_addr,
    output logic [7:0]       wr_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int   busy_cnt;
    logic active;

    // ============================================================
    // Answer timing
    assign active = !read_n || !write_n || !data_strobe_n;
    // Clocks spent in the current strobe phase
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !active) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    // Slow answer holds ready low early enough to earn waits
    assign ready_pin = !(active && busy_cnt < stall);
    // Acknowledge dropped as soon as the strobes go away
    assign transfer_ack_n = !(!data_strobe_n && busy_cnt >= stall);
    // Released bus shows the inverse so a stale byte never matches
    assign data_in = (!read_n || (!data_strobe_n && read_write)) ? rd_byte : ~rd_byte;

    // ============================================================
    // What the peripheral latches from the device
    always_ff @(posedge ref_clk) begin
        if (addr_latch_en && !data_oe_n) begin
            lat_addr <= data_out;
        end
        if (!addr_strobe_n) begin
            bus_addr <= addr;
        end
        if (!data_oe_n && (!write_n || (!data_strobe_n && !read_write))) begin
            wr_byte <= data_out;
        end
    end
endmodule // ebms_periph_model

// ### dv/ext_bus_mux_and_strobe_modes_test.sv
// Self-checking bench for the external bus sequencer
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module ext_bus_mux_and_strobe_modes_test
    import ebms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, req_valid, req_write, req_io, req_strobe_mode, req_ready, rsp_valid;
    logic [23:0] req_addr, addr, bus_addr;
    logic [7:0]  req_wdata, rsp_rdata, data_out, data_in, stall, rd_byte, lat_addr, wr_byte, got_rdata;
    logic [3:0]  state_len;
    logic data_oe_n, chip_sel_n, addr_latch_en, read_n, write_n, memory_request_n, io_request_n;
    logic addr_strobe_n, data_strobe_n, read_write, ready_pin, transfer_ack_n;
    int n_cs, n_ale, n_rd, n_wr, n_mrq, n_io_request_n, n_as, n_ds, n_rwl, n_oe, errors, samples_checked;

    ebms_bus_seq uut (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
        .req_io(req_io), .req_strobe_mode(req_strobe_mode), .req_addr(req_addr), .req_wdata(req_wdata),
        .state_len(state_len), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .chip_sel_n(chip_sel_n),
        .addr_latch_en(addr_latch_en), .read_n(read_n), .write_n(write_n), .memory_request_n(memory_request_n),
        .io_request_n(io_request_n), .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
        .read_write(read_write), .ready_pin(ready_pin), .transfer_ack_n(transfer_ack_n));
    ebms_periph_model peer (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .data_out(data_out),
        .data_oe_n(data_oe_n), .addr_latch_en(addr_latch_en), .read_n(read_n), .write_n(write_n),
        .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n), .read_write(read_write),
        .data_in(data_in), .ready_pin(ready_pin), .transfer_ack_n(transfer_ack_n), .stall(stall),
        .rd_byte(rd_byte), .lat_addr(lat_addr), .bus_addr(bus_addr), .wr_byte(wr_byte));

    // ============================================================
    // Clock and phase-length counters, cleared at each request
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (req_valid) begin
            {n_cs, n_ale, n_rd, n_wr, n_mrq, n_io_request_n, n_as, n_ds, n_rwl, n_oe} <= '0;
        end else begin
            n_cs <= n_cs + !chip_sel_n;
            n_ale <= n_ale + addr_latch_en;
            n_rd <= n_rd + !read_n;
            n_wr <= n_wr + !write_n;
            n_mrq <= n_mrq + !memory_request_n;
            n_io_request_n <= n_io_request_n + !io_request_n;
            n_as <= n_as + !addr_strobe_n;
            n_ds <= n_ds + !data_strobe_n;
            n_rwl <= n_rwl + !read_write;
            n_oe <= n_oe + !data_oe_n;
        end
        if (rsp_valid) begin
            got_rdata <= rsp_rdata;
        end else if (req_valid) begin
            got_rdata <= ~req_wdata;
        end
    end

    // ============================================================
    // Shared tasks
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One bus cycle, one edge of request, then wait for idle
    task automatic run(input logic wr, io, sm, input logic [3:0] len, input logic [23:0] a,
                       input logic [7:0] d, st);
        int w;
        w = 0;
        while (req_ready !== 1'b1 && w < 100) begin
            @(posedge ref_clk);
            w++;
        end
        req_write <= wr;
        req_io <= io;
        req_strobe_mode <= sm;
        state_len <= len;
        req_addr <= a;
        req_wdata <= d;
        rd_byte <= d;
        stall <= st;
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        while (req_ready !== 1'b1 && w < 3000) begin
            @(posedge ref_clk);
            w++;
        end
        if (w >= 3000) begin
            errors++;
            report_and_stop();
        end
        repeat (2) @(posedge ref_clk);
        `CHK("idle_pins", 10'h2FF, {chip_sel_n, addr_latch_en, read_n, write_n, memory_request_n, io_request_n,
            addr_strobe_n, data_strobe_n, read_write, data_oe_n})
        `CHK("latch_addr_byte", a[7:0], sm ? bus_addr[7:0] : lat_addr)
        `CHK("data_seen", d, wr ? wr_byte : got_rdata)
    endtask
    // Latch-mode phase lengths with k whole waits
    task automatic chk_latch(input logic wr, io, input int el, k);
        `CHK("cs_low", 4*el+k*el, n_cs)
        `CHK("ale_high", el/2, n_ale)
        `CHK("strobe_low", 2*el+k*el, wr ? n_wr : n_rd)
        `CHK("req_low", 3*el+k*el, io ? n_io_request_n : n_mrq)
        `CHK("other_req", 0, io ? n_mrq : n_io_request_n)
        `CHK("oe_low", wr ? 4*el+k*el : el, n_oe)
    endtask
    // Strobe-mode phase lengths with k whole waits
    task automatic chk_strobe(input logic wr, input int el, k, input logic [23:0] a);
        `CHK("as_low", 5*el+k*el, n_as)
        `CHK("ds_low", (wr ? 3 : 5)*el+k*el, n_ds)
        `CHK("rw_low", wr ? 6*el+k*el : 0, n_rwl)
        `CHK("oe_low", wr ? 5*el+k*el : 0, n_oe)
        `CHK("bus_addr", a, bus_addr)
    endtask

    // ============================================================
    // Scenarios
    task automatic s_latch_read_min();
        run(1'b0, 1'b0, 1'b0, 4'h2, 24'hABCD5A, 8'hE7, 8'h00);
        chk_latch(1'b0, 1'b0, 2, 0);
    endtask
    task automatic s_latch_write_io_max();
        run(1'b1, 1'b1, 1'b0, 4'hF, 24'h0312C3, 8'h96, 8'h00);
        chk_latch(1'b1, 1'b1, 15, 0);
    endtask
    // Slow peripheral: waits come in whole states
    task automatic s_latch_read_wait();
        int k;
        run(1'b0, 1'b1, 1'b0, 4'h3, 24'h00FF81, 8'h3C, 8'h0A);
        k = (n_rd - 6) / 3;
        `CHK("latch_waits", 1'b1, (n_rd - 6) % 3 == 0 && k >= 1)
        chk_latch(1'b0, 1'b1, 3, k);
    endtask
    // Too short a length is raised to the floor
    task automatic s_len_floor();
        run(1'b1, 1'b0, 1'b0, 4'h1, 24'h77AA11, 8'h5A, 8'h00);
        chk_latch(1'b1, 1'b0, 2, 0);
    endtask
    task automatic s_strobe_write_wait();
        int k;
        run(1'b1, 1'b0, 1'b1, 4'h2, 24'hC0FFEE, 8'hA1, 8'h0C);
        k = (n_as - 10) / 2;
        `CHK("strobe_waits", 1'b1, (n_as - 10) % 2 == 0 && k >= 1)
        chk_strobe(1'b1, 2, k, 24'hC0FFEE);
    endtask
    // Read right after a write must start with direction high
    task automatic s_strobe_read();
        run(1'b0, 1'b0, 1'b1, 4'h4, 24'h123456, 8'h69, 8'h00);
        chk_strobe(1'b0, 4, 0, 24'h123456);
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial begin
        {reset_n, req_valid, req_write, req_io, req_strobe_mode} = '0;
        {req_addr, req_wdata, rd_byte, stall} = '0;
        state_len = 4'h2;
        errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        s_latch_read_min();
        s_latch_write_io_max();
        s_latch_read_wait();
        s_len_floor();
        s_strobe_write_wait();
        s_strobe_read();
        report_and_stop();
    end
    // Whole run needs well under two thousand clocks
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end
endmodule // ext_bus_mux_and_strobe_modes_test

// ### rtl/ebms_bus_seq.sv
// External bus cycle sequencer: latch-enable and strobe-handshake modes
module ebms_bus_seq
    import ebms_pkg::*;
#(
    parameter int ADDR_W = EBMS_ADDR_W,
    parameter int DATA_W = EBMS_DATA_W
)(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Request side
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_io,
    input  wire logic              req_strobe_mode,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [3:0]        state_len,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    // External bus pins
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic                   chip_sel_n,
    output logic                   addr_latch_en,
    output logic                   read_n,
    output logic                   write_n,
    output logic                   memory_request_n,
    output logic                   io_request_n,
    output logic                   addr_strobe_n,
    output logic                   data_strobe_n,
    output logic                   read_write,
    input  wire logic              ready_pin,
    input  wire logic              transfer_ack_n
);
    // Elaboration check: the address low byte must fit the data bus
    if (ADDR_W < DATA_W || DATA_W < 1) begin : g_bad_width
        $error("ebms_bus_seq: address must be at least data width");
    end

    ebms_state_t state;
    logic        wr;
    logic        io;
    logic        smode;
    logic [3:0]  slen;
    logic [2:0]  sidx;
    logic [ADDR_W-1:0] a_q;
    logic [DATA_W-1:0] d_q;
    logic [2:0]  rdy_sync;
    logic [2:0]  ack_sync;
    logic        rdy;
    logic        ack;
    logic        st_mid;
    logic        st_end;
    logic        restart;
    logic [3:0]  cur_len;

    // Checks below all run on the system clock and sleep in reset
    default clocking ebms_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // ============================================================
    // Pin synchronisers; level counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdy_sync <= 3'h7;
            ack_sync <= 3'h7;
        end else begin
            rdy_sync <= {rdy_sync[1:0], ready_pin};
            ack_sync <= {ack_sync[1:0], transfer_ack_n};
        end
    end

    // Filtered levels hold until stages agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdy <= 1'b1;
            ack <= 1'b0;
        end else begin
            if (rdy_sync[1] == rdy_sync[2]) begin
                rdy <= rdy_sync[2];
            end
            if (ack_sync[1] == ack_sync[2]) begin
                ack <= !ack_sync[2];
            end
        end
    end

    // ============================================================
    // State timer; strobe mode uses same length, minimum 2 clocks
    assign restart = (state == EBMS_IDLE);
    assign cur_len = (slen < EBMS_LEN_MIN) ? EBMS_LEN_MIN : slen;

    ebms_state_timer u_timer (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .restart   (restart),
        .state_len (cur_len),
        .state_mid (st_mid),
        .state_end (st_end)
    );

    // ============================================================
    // Cycle sequencer. Latch mode: P1..P4 are T1..T4.
    // Strobe mode: P1 steps S0..S7 via sidx, WAIT after S4, P4 is S7 exit.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= EBMS_IDLE;
            sidx  <= 3'h0;
            wr    <= 1'b0;
            io    <= 1'b0;
            smode <= 1'b0;
            slen  <= EBMS_LEN_RESET;
            a_q   <= '0;
            d_q   <= '0;
        end else begin
            unique case (state)
                EBMS_IDLE: begin
                    if (req_valid) begin
                        state <= EBMS_P1;
                        sidx  <= 3'h0;
                        wr    <= req_write;
                        io    <= req_io;
                        smode <= req_strobe_mode;
                        slen  <= state_len;
                        a_q   <= req_addr;
                        d_q   <= req_wdata;
                    end
                end
                EBMS_P1: begin
                    if (st_end) begin
                        if (!smode) begin
                            state <= EBMS_P2;
                        end else if (sidx == 3'h4 && !ack) begin
                            state <= EBMS_WAIT;
                        end else if (sidx == EBMS_LAST_S) begin
                            state <= EBMS_P4;
                        end else begin
                            sidx <= sidx + 3'h1;
                        end
                    end
                end
                EBMS_P2: begin
                    if (st_end) begin
                        state <= EBMS_P3;
                    end
                end
                EBMS_P3: begin
                    // Ready seen low when T3 ends sends the state into waits
                    if (st_end) begin
                        state <= rdy ? EBMS_P4 : EBMS_WAIT;
                    end
                end
                EBMS_WAIT: begin
                    // Each wait is one whole bus state
                    if (st_end) begin
                        if (smode && ack) begin
                            state <= EBMS_P1;
                            sidx  <= 3'h5;
                        end else if (!smode && rdy) begin
                            state <= EBMS_P4;
                        end
                    end
                end
                EBMS_P4: begin
                    // Strobe mode P4 is a single-clock exit after S7
                    if (st_end || smode) begin
                        state <= EBMS_IDLE;
                    end
                end
                default: begin
                    state <= EBMS_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Latch-mode pins; bus held unchanged through T3 and waits
    always_ff @(posedge ref_clk) begin
        if (!reset_n || state == EBMS_IDLE || smode) begin
            chip_sel_n       <= !(state == EBMS_IDLE && req_valid && !req_strobe_mode) || !reset_n;
            addr_latch_en    <= reset_n && state == EBMS_IDLE && req_valid && !req_strobe_mode;
            read_n           <= 1'b1;
            write_n          <= 1'b1;
            memory_request_n <= 1'b1;
            io_request_n     <= 1'b1;
        end else begin
            chip_sel_n <= (state == EBMS_P4 && st_end);
            if (state == EBMS_P1 && st_mid) begin
                addr_latch_en <= 1'b0;
            end
            if (state == EBMS_P1 && st_end) begin
                read_n           <= wr;
                write_n          <= !wr;
                memory_request_n <= io;
                io_request_n     <= !io;
            end
            if (state == EBMS_P3 && st_end && rdy || state == EBMS_WAIT && st_end && rdy) begin
                read_n  <= 1'b1;
                write_n <= 1'b1;
            end
            if (state == EBMS_P4 && st_end) begin
                memory_request_n <= 1'b1;
                io_request_n     <= 1'b1;
            end
        end
    end

    // ============================================================
    // Shared address and data pins, strobe-mode pins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr          <= '0;
            data_out      <= '0;
            data_oe_n     <= 1'b1;
            addr_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            read_write    <= 1'b1;
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
            req_ready     <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= (state == EBMS_IDLE) && !req_valid;
            if (state == EBMS_IDLE && req_valid) begin
                if (!req_strobe_mode) begin
                    addr      <= req_addr;
                    data_out  <= req_addr[DATA_W-1:0];
                    data_oe_n <= 1'b0;
                end
                read_write <= 1'b1;
            end
            if (!smode && state == EBMS_P1 && st_end) begin
                data_out  <= d_q;
                data_oe_n <= !wr;
            end
            if (smode && state == EBMS_P1 && st_end) begin
                unique case (sidx)
                    3'h0: addr <= a_q;
                    3'h1: begin
                        addr_strobe_n <= 1'b0;
                        data_strobe_n <= wr;
                        read_write    <= !wr;
                    end
                    3'h2: begin
                        data_out  <= d_q;
                        data_oe_n <= !wr;
                    end
                    3'h3: data_strobe_n <= 1'b0;
                    3'h6: begin
                        addr_strobe_n <= 1'b1;
                        data_strobe_n <= 1'b1;
                        if (!wr) begin
                            rsp_rdata <= data_in;
                            rsp_valid <= 1'b1;
                        end
                    end
                    3'h7: begin
                        read_write <= 1'b1;
                        data_oe_n  <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            // Read data captured at the T4 boundary
            if (!smode && !wr && st_end && rdy && (state == EBMS_P3 || state == EBMS_WAIT)) begin
                rsp_rdata <= data_in;
                rsp_valid <= 1'b1;
            end
            if ((state == EBMS_P4 && st_end) || (smode && state == EBMS_P4)) begin
                data_oe_n <= 1'b1;
            end
        end
    end

    // ============================================================
    // Checks
    // Latch-mode cycle
    a_ale_mid_low: assert property ((state == EBMS_P1 && !smode && st_mid)
        |=> !addr_latch_en)
        else $error("latch enable not low after mid T1");
    a_t1_start: assert property ((state == EBMS_IDLE && req_valid && !req_strobe_mode)
        |=> !chip_sel_n && addr_latch_en && !data_oe_n && data_out == $past(req_addr[DATA_W-1:0]))
        else $error("T1 did not put address on data bus");
    a_t2_read: assert property ((state == EBMS_P1 && !smode && !wr && st_end)
        |=> !read_n && data_oe_n && (memory_request_n != io_request_n))
        else $error("T2 read strobes wrong");
    a_t2_write: assert property ((state == EBMS_P1 && !smode && wr && st_end)
        |=> !write_n && !data_oe_n && data_out == d_q)
        else $error("T2 write data missing");
    a_t3_hold: assert property ((state == EBMS_P3)
        |-> $stable(read_n) && $stable(write_n) && $stable(data_oe_n) && $stable(data_out) && $stable(chip_sel_n))
        else $error("bus changed during T3");
    a_wait_ready: assert property ((state == EBMS_P3 && st_end && !rdy)
        |=> state == EBMS_WAIT)
        else $error("no wait with ready low");
    a_wait_hold: assert property ((state == EBMS_WAIT && !smode && st_end && !rdy)
        |=> state == EBMS_WAIT)
        else $error("wait ended with ready low");
    a_read_capture: assert property ((state inside {EBMS_P3, EBMS_WAIT} && !smode && !wr && st_end && rdy)
        |=> rsp_valid && read_n && rsp_rdata == $past(data_in))
        else $error("T4 read data not captured");
    a_t4_write: assert property ((state inside {EBMS_P3, EBMS_WAIT} && !smode && wr && st_end && rdy)
        |=> write_n && !data_oe_n && !chip_sel_n && $stable(data_out))
        else $error("T4 write did not hold bus");
    a_idle_quiet: assert property ((state == EBMS_IDLE && $past(state) == EBMS_IDLE)
        |-> data_oe_n && addr_strobe_n && read_n && write_n)
        else $error("bus active while idle");
    // Strobe-mode cycle
    a_s0_dir: assert property ((state == EBMS_IDLE && req_valid && req_strobe_mode)
        |=> read_write)
        else $error("direction not high in S0");
    a_s1_addr: assert property ((state == EBMS_P1 && smode && sidx == 3'h0 && st_end)
        |=> addr == a_q)
        else $error("address not valid in S1");
    a_s2_strobes: assert property ((state == EBMS_P1 && smode && !wr && sidx == 3'h1 && st_end)
        |=> !addr_strobe_n && !data_strobe_n)
        else $error("strobes not asserted at S2");
    a_s2_write: assert property ((state == EBMS_P1 && smode && wr && sidx == 3'h1 && st_end)
        |=> !addr_strobe_n && data_strobe_n && !read_write)
        else $error("S2 write strobe or direction wrong");
    a_s3_drive: assert property ((state == EBMS_P1 && smode && wr && sidx == 3'h2 && st_end)
        |=> !data_oe_n && data_out == d_q)
        else $error("write data not driven in S3");
    a_s4_dstrobe: assert property ((state == EBMS_P1 && smode && wr && sidx == 3'h3 && st_end)
        |=> !data_strobe_n)
        else $error("data strobe not asserted at S4");
    a_ack_wait: assert property ((state == EBMS_P1 && smode && sidx == 3'h4 && st_end && !ack)
        |=> state == EBMS_WAIT)
        else $error("no wait without acknowledge");
    a_s7_release: assert property ((state == EBMS_P1 && smode && sidx == 3'h6 && st_end)
        |=> addr_strobe_n && data_strobe_n)
        else $error("strobes not released at S7");
    a_s7_capture: assert property ((state == EBMS_P1 && smode && !wr && sidx == 3'h6 && st_end)
        |=> rsp_valid && rsp_rdata == $past(data_in))
        else $error("S7 read data not captured");
    a_s7_end: assert property ((state == EBMS_P1 && smode && sidx == EBMS_LAST_S && st_end)
        |=> read_write && data_oe_n)
        else $error("bus not released after S7");
    a_write_dir: assert property ((state == EBMS_P4 && smode)
        |-> read_write)
        else $error("direction not high after S7");
endmodule // ebms_bus_seq

// ### rtl/ebms_pkg.sv
// Package of constants for the external bus sequencer
// ============================================================
// What this block does
// - Latch mode cycle runs T1 to T4, waits after T3
// - T1 read drives address on data, chip select
// - Latch enable high at T1 start, low mid-T1
// - T2 read releases data, asserts read and request
// - Ready low before T3 inserts waits until high
// - T3 leaves all bus outputs unchanged
// - T4 read captures data, drops read, ends
// - Latch write starts T1 with address and pulse
// - T2 write swaps address for data, asserts write
// - T4 write drops strobe, holds bus through T4
// - Strobe mode cycle runs S0 to S7 plus waits
// - Strobe read: direction high S0, address S1
// - Strobe read asserts both strobes entering S2
// - Late acknowledge inserts whole waits after S4
// - Entering S7 read captures data, drops strobes
// - Strobe write S0 returns direction high
// - Strobe write S2 asserts address strobe, direction low
// - Strobe write S3 turns on data drivers
// - Strobe write S4 asserts data strobe, waits
// - Write S7 drops strobes, direction high after
// - Latch state length programmable 2 to 15 clocks
package ebms_pkg;
    // ============================================================
    // Widths and timing
    localparam int            EBMS_ADDR_W      = 24;
    localparam int            EBMS_DATA_W      = 8;
    localparam int            EBMS_LEN_W       = 4;
    localparam logic [3:0]    EBMS_LEN_MIN     = 4'h2;
    localparam logic [3:0]    EBMS_LEN_MAX     = 4'hF;
    localparam logic [3:0]    EBMS_LEN_RESET   = 4'h2;
    localparam logic [2:0]    EBMS_LAST_S      = 3'h7;

    // ============================================================
    // Sequencer states
    typedef enum logic [5:0] {
        EBMS_IDLE = 6'h01,
        EBMS_P1   = 6'h02,
        EBMS_P2   = 6'h04,
        EBMS_P3   = 6'h08,
        EBMS_WAIT = 6'h10,
        EBMS_P4   = 6'h20
    } ebms_state_t;
endpackage : ebms_pkg

// ### rtl/ebms_state_timer.sv
// Bus state length counter producing mid and end pulses
module ebms_state_timer
    import ebms_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // Control
    input  wire logic                  restart,
    input  wire logic [EBMS_LEN_W-1:0] state_len,
    // Pulses
    output logic                       state_mid,
    output logic                       state_end
);
    logic [EBMS_LEN_W-1:0] count;

    // ============================================================
    // Count clocks within one bus state
    always_ff @(posedge ref_clk) begin
        if (!reset_n || restart || state_end) begin
            count <= '0;
        end else begin
            count <= count + 4'h1;
        end
    end

    // Mid pulse on the clock before the half-way edge, so the first half is floor(len/2) clocks
    assign state_mid = (count == {1'b0, state_len[EBMS_LEN_W-1:1]} - 4'h1) && !restart;
    assign state_end = (count == state_len - 4'h1) && !restart;
endmodule // ebms_state_timer
